// ### rtl/spl_lock_control.v
// Self-programming control, boot lock bits and boot reset selection.
// Assumes the CPU core drives store/load request pulses synchronous to clk_sys
// and the flash array reports the end of an erase or write with a pulse.
`timescale 1ns/100ps
`include "spl_lock_consts.vh"

module spl_lock_control #(
    parameter AW        = 12,
    parameter LOCK_INIT = 8'hff
) (
    // Clock and reset
    input  wire          clk_sys,
    input  wire          resetn,
    // AXI4-Lite slave
    input  wire [3:0]    s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output reg           s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output reg           s_axi_wready,
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    input  wire [3:0]    s_axi_araddr,
    input  wire          s_axi_arvalid,
    output reg           s_axi_arready,
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready,
    // CPU core
    input  wire [AW-1:0] execAddr,
    input  wire          globalIrqFlag,
    input  wire          storeReq,
    input  wire [AW-1:0] storeAddr,
    input  wire [15:0]   storeWord,
    input  wire          loadReq,
    input  wire [AW:0]   loadAddr,
    output reg           storeRefused_r,
    output reg           loadGrant_r,
    output reg           loadRefused_r,
    output reg           lockReadValid_r,
    output reg  [7:0]    lockReadData_r,
    output reg           storeReadyIrq_r,
    output reg           irqSuppress_r,
    output reg           cpuStall_r,
    output reg  [AW-1:0] resetVector_r,
    // Flash array
    input  wire [AW-1:0] bootStart,
    input  wire [AW-1:0] nrwwStart,
    input  wire          flashDone,
    output reg           flashEraseStart_r,
    output reg           flashWriteStart_r,
    output reg  [AW-1:0] flashPageAddr_r,
    output reg           pageLoadWe_r,
    output reg  [AW-1:0] pageLoadAddr_r,
    output reg  [15:0]   pageLoadData_r,
    output reg           pageBufClear_r,
    // Fuses and external programming path
    input  wire          bootResetSelectFuse,
    input  wire [7:0]    fuseLowByte,
    input  wire          progLockWe,
    input  wire [7:0]    progLockData,
    input  wire          chipErase
);

    // Section decode, used for both execution and target addresses
    function inBoot;
        input [AW-1:0] a;
        input [AW-1:0] start;
        begin
            inBoot = (a >= start);
        end
    endfunction

    reg          storeReadyIrqEn_r;
    reg          rwwSectionBusyFlag_r;
    reg          rwwSectionReadReenable_r;
    reg          lockBitsSetCommand_r;
    reg          pageWriteCmd_r;
    reg          pageEraseCmd_r;
    reg          selfProgramArm_r;
    reg          opBusy_r;
    reg  [2:0]   armCnt_r;
    reg  [7:0]   lockBits_r;
    reg          ivInBoot_r;
    reg  [3:0]   wrAddr_r;
    reg  [31:0]  wrData_r;
    reg  [3:0]   wrStrb_r;

    wire [7:0] csrView = {storeReadyIrqEn_r, rwwSectionBusyFlag_r, 1'b0,
                          rwwSectionReadReenable_r, lockBitsSetCommand_r,
                          pageWriteCmd_r, pageEraseCmd_r, selfProgramArm_r};

    // Memory lock bits guard external access only,
    // so no store/load check reads them.
    wire appLo  = lockBits_r[`SPL_LOCK_APP_LO];
    wire appHi  = lockBits_r[`SPL_LOCK_APP_HI];
    wire bootLo = lockBits_r[`SPL_LOCK_BOOT_LO];
    wire bootHi = lockBits_r[`SPL_LOCK_BOOT_HI];

    wire execBoot   = inBoot(execAddr, bootStart);
    wire storeBoot  = inBoot(storeAddr, bootStart);
    wire storeNrww  = inBoot(storeAddr, nrwwStart);
    wire loadBoot   = inBoot(loadAddr[AW:1], bootStart);
    wire loadNrww   = inBoot(loadAddr[AW:1], nrwwStart);

    // Store write protection per target section
    wire appStoreBlocked  = !appLo;
    wire bootStoreBlocked = !bootLo;
    wire storeBlocked = storeBoot ? bootStoreBlocked : appStoreBlocked;

    // Load read protection depends on where the code runs
    wire loadBlocked = (!appHi && execBoot && !loadBoot) ||
                       (!bootHi && !execBoot && loadBoot) ||
                       (rwwSectionBusyFlag_r && !loadNrww);

    wire armed     = selfProgramArm_r && (armCnt_r != 3'd0) && !opBusy_r;
    wire storeGo   = storeReq && armed && execBoot;
    wire lockPeek  = lockBitsSetCommand_r && selfProgramArm_r &&
                     (armCnt_r > (`SPL_ARM_CYCLES - `SPL_LPM_CYCLES));

    // AXI write decode and command check
    wire wrDo = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire wrCsr = wrDo && (wrAddr_r == `SPL_OFF_CSR) && wrStrb_r[0];
    wire wrCfg = wrDo && (wrAddr_r == `SPL_OFF_CFG) && wrStrb_r[0];
    wire wrMapped = (wrAddr_r == `SPL_OFF_CSR) || (wrAddr_r == `SPL_OFF_LOCK) ||
                    (wrAddr_r == `SPL_OFF_CFG);
    wire [4:0] wrCmd = wrData_r[4:0];
    wire cmdOk = (wrCmd == `SPL_CMD_REEN) || (wrCmd == `SPL_CMD_LOCK) ||
                 (wrCmd == `SPL_CMD_WRITE) || (wrCmd == `SPL_CMD_ERASE) ||
                 (wrCmd == `SPL_CMD_LOAD);
    // Command bits are frozen while erase/write runs
    wire cmdTake = wrCsr && cmdOk && !opBusy_r;

    // AXI write channel: address and data taken in either order
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SPL_RESP_OKAY;
            wrAddr_r      <= 4'h0;
            wrData_r      <= 32'h0000_0000;
            wrStrb_r      <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                wrAddr_r      <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wrData_r     <= s_axi_wdata;
                wrStrb_r     <= s_axi_wstrb;
            end
            if (wrDo) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrMapped ? `SPL_RESP_OKAY : `SPL_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // AXI read channel: data sampled at the address handshake
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `SPL_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `SPL_RESP_OKAY;
                case (s_axi_araddr)
                    `SPL_OFF_CSR:  s_axi_rdata <= {24'h000000, csrView};
                    `SPL_OFF_LOCK: s_axi_rdata <= {23'h000000, bootResetSelectFuse,
                                                   lockBits_r};
                    `SPL_OFF_CFG:  s_axi_rdata <= {31'h00000000, ivInBoot_r};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `SPL_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Control byte, arm window and store execution
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            storeReadyIrqEn_r        <= 1'b0;
            rwwSectionBusyFlag_r     <= 1'b0;
            rwwSectionReadReenable_r <= 1'b0;
            lockBitsSetCommand_r     <= 1'b0;
            pageWriteCmd_r           <= 1'b0;
            pageEraseCmd_r           <= 1'b0;
            selfProgramArm_r         <= 1'b0;
            opBusy_r                 <= 1'b0;
            armCnt_r                 <= 3'd0;
            ivInBoot_r               <= `SPL_CFG_RESET;
            storeRefused_r           <= 1'b0;
            cpuStall_r               <= 1'b0;
            flashEraseStart_r        <= 1'b0;
            flashWriteStart_r        <= 1'b0;
            flashPageAddr_r          <= {AW{1'b0}};
            pageLoadWe_r             <= 1'b0;
            pageLoadAddr_r           <= {AW{1'b0}};
            pageLoadData_r           <= 16'h0000;
            pageBufClear_r           <= 1'b0;
            lockBits_r               <= LOCK_INIT;
        end else begin
            storeRefused_r    <= 1'b0;
            flashEraseStart_r <= 1'b0;
            flashWriteStart_r <= 1'b0;
            pageLoadWe_r      <= 1'b0;
            pageBufClear_r    <= 1'b0;
            if (wrCfg)
                ivInBoot_r <= wrData_r[`SPL_CFG_IV_BOOT];
            if (wrCsr)
                storeReadyIrqEn_r <= wrData_r[`SPL_CSR_IRQ_EN];
            if (armCnt_r != 3'd0)
                armCnt_r <= armCnt_r - 3'd1;
            // No store in the window: drop all command bits
            if (armCnt_r == 3'd1 && !opBusy_r) begin
                selfProgramArm_r         <= 1'b0;
                rwwSectionReadReenable_r <= 1'b0;
                lockBitsSetCommand_r     <= 1'b0;
                pageWriteCmd_r           <= 1'b0;
                pageEraseCmd_r           <= 1'b0;
            end
            if (storeReq && !storeGo)
                storeRefused_r <= 1'b1;
            if (storeGo) begin
                armCnt_r                 <= 3'd0;
                selfProgramArm_r         <= 1'b0;
                rwwSectionReadReenable_r <= 1'b0;
                lockBitsSetCommand_r     <= 1'b0;
                pageWriteCmd_r           <= 1'b0;
                pageEraseCmd_r           <= 1'b0;
                if (pageEraseCmd_r || pageWriteCmd_r) begin
                    if (storeBlocked) begin
                        storeRefused_r <= 1'b1;
                    end else begin
                        // Arm bit stays high for the whole operation
                        selfProgramArm_r  <= 1'b1;
                        pageWriteCmd_r    <= pageWriteCmd_r;
                        pageEraseCmd_r    <= pageEraseCmd_r;
                        opBusy_r          <= 1'b1;
                        flashEraseStart_r <= pageEraseCmd_r;
                        flashWriteStart_r <= pageWriteCmd_r;
                        flashPageAddr_r   <= storeAddr;
                        if (storeNrww)
                            cpuStall_r <= 1'b1;
                        else
                            rwwSectionBusyFlag_r <= 1'b1;
                    end
                end else if (lockBitsSetCommand_r) begin
                    // AND only moves bits toward programmed
                    lockBits_r <= lockBits_r & storeWord[7:0];
                end else if (rwwSectionReadReenable_r) begin
                    rwwSectionBusyFlag_r <= 1'b0;
                    pageBufClear_r       <= 1'b1;
                end else begin
                    pageLoadWe_r         <= 1'b1;
                    pageLoadAddr_r       <= storeAddr;
                    pageLoadData_r       <= storeWord;
                    rwwSectionBusyFlag_r <= 1'b0;
                end
            end
            if (opBusy_r && flashDone) begin
                opBusy_r         <= 1'b0;
                selfProgramArm_r <= 1'b0;
                pageWriteCmd_r   <= 1'b0;
                pageEraseCmd_r   <= 1'b0;
                cpuStall_r       <= 1'b0;
                // Written page empties the temporary buffer
                pageBufClear_r   <= pageWriteCmd_r;
            end
            if (cmdTake) begin
                selfProgramArm_r         <= wrCmd[`SPL_CSR_ARM];
                pageEraseCmd_r           <= wrCmd[`SPL_CSR_PAGE_ER];
                pageWriteCmd_r           <= wrCmd[`SPL_CSR_PAGE_WR];
                lockBitsSetCommand_r     <= wrCmd[`SPL_CSR_LOCK_SET];
                rwwSectionReadReenable_r <= wrCmd[`SPL_CSR_RWW_REEN];
                armCnt_r                 <= `SPL_ARM_CYCLES;
                if (wrCmd == `SPL_CMD_REEN)
                    pageBufClear_r <= 1'b1;
            end
            // Only chip erase unprograms
            if (progLockWe)
                lockBits_r <= lockBits_r & progLockData;
            if (chipErase)
                lockBits_r <= `SPL_LOCK_ERASED;
        end
    end

    // Load path: lock/fuse peek, grant or silent refusal
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            loadGrant_r     <= 1'b0;
            loadRefused_r   <= 1'b0;
            lockReadValid_r <= 1'b0;
            lockReadData_r  <= 8'h00;
        end else begin
            loadGrant_r     <= 1'b0;
            loadRefused_r   <= 1'b0;
            lockReadValid_r <= 1'b0;
            if (loadReq) begin
                if (lockPeek) begin
                    lockReadValid_r <= 1'b1;
                    lockReadData_r  <= loadAddr[0] ? fuseLowByte : lockBits_r;
                end else if (loadBlocked) begin
                    loadRefused_r <= 1'b1;
                end else begin
                    loadGrant_r <= 1'b1;
                end
            end
        end
    end

    // Interrupt request, suppression and reset vector
    wire appMode34  = !appHi;
    wire bootMode34 = !bootHi;
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            storeReadyIrq_r <= 1'b0;
            irqSuppress_r   <= 1'b0;
            resetVector_r   <= {AW{1'b0}};
        end else begin
            storeReadyIrq_r <= storeReadyIrqEn_r && globalIrqFlag &&
                               !selfProgramArm_r;
            irqSuppress_r   <= (appMode34 && ivInBoot_r && !execBoot) ||
                               (bootMode34 && !ivInBoot_r && execBoot);
            // Fuse has no software write path
            resetVector_r   <= bootResetSelectFuse ? {AW{1'b0}} : bootStart;
        end
    end

endmodule // spl_lock_control

// ### shared/spl_lock_consts.vh
// Constants for the self-programming lock and control block.
// Assumes a 32-bit AXI4-Lite register bus and an 8-bit control and status byte.
`ifndef SPL_LOCK_CONSTS_VH
`define SPL_LOCK_CONSTS_VH

// Register byte offsets
`define SPL_OFF_CSR         4'h0
`define SPL_OFF_LOCK        4'h4
`define SPL_OFF_CFG         4'h8

// Control and status byte, bit positions
`define SPL_CSR_IRQ_EN      7
`define SPL_CSR_RWW_BUSY    6
`define SPL_CSR_RES         5
`define SPL_CSR_RWW_REEN    4
`define SPL_CSR_LOCK_SET    3
`define SPL_CSR_PAGE_WR     2
`define SPL_CSR_PAGE_ER     1
`define SPL_CSR_ARM         0
`define SPL_CSR_RESET       8'h00

// Accepted command patterns of the low five bits
`define SPL_CMD_REEN        5'h11
`define SPL_CMD_LOCK        5'h09
`define SPL_CMD_WRITE       5'h05
`define SPL_CMD_ERASE       5'h03
`define SPL_CMD_LOAD        5'h01

// Lock byte layout: 1 = unprogrammed, 0 = programmed
`define SPL_LOCK_MEM_LO     0
`define SPL_LOCK_MEM_HI     1
`define SPL_LOCK_APP_LO     2
`define SPL_LOCK_APP_HI     3
`define SPL_LOCK_BOOT_LO    4
`define SPL_LOCK_BOOT_HI    5
`define SPL_LOCK_ERASED     8'hff

// Config register
`define SPL_CFG_IV_BOOT     0
`define SPL_CFG_RESET       1'b0

// Timing in clock cycles
`define SPL_ARM_CYCLES      3'd4
`define SPL_LPM_CYCLES      3'd3

// AXI responses
`define SPL_RESP_OKAY       2'b00
`define SPL_RESP_SLVERR     2'b10

`endif

// ### verif/spl_cpu_model.sv
// CPU core and flash array model facing the lock control block.
// Assumes its tasks are called just after a rising edge of clk_sys.
`timescale 1ns/100ps
module spl_cpu_model (
    // Clock
    input  wire        clk_sys,
    // Erase or write started by the block
    input  wire        opStart,
    // Core requests
    output reg         storeReq  = 1'b0,
    output reg  [11:0] storeAddr = 12'h000,
    output reg  [15:0] storeWord = 16'h0000,
    output reg         loadReq   = 1'b0,
    output reg  [12:0] loadAddr  = 13'h0000,
    // Flash completion
    output reg         flashDone = 1'b0
);
    // Lands inside the four-cycle arm window after a command write
    task store(input [11:0] a, input [15:0] w);
        storeReq  <= 1'b1;
        storeAddr <= a;
        storeWord <= w;
        @(posedge clk_sys);
        storeReq  <= 1'b0;
    endtask

    task load(input [12:0] a);
        loadReq  <= 1'b1;
        loadAddr <= a;
        @(posedge clk_sys);
        loadReq  <= 1'b0;
    endtask

    // Random 20..51 cycle operation so the bench's RWW-busy refused loads land mid-operation
    always @(posedge clk_sys) begin
        if (opStart) begin
            repeat (20 + $urandom % 32) @(posedge clk_sys);
            flashDone <= 1'b1;
            @(posedge clk_sys);
            flashDone <= 1'b0;
        end
    end
endmodule // spl_cpu_model

// ### verif/spl_lock_control_chk.sv
// Port-level checker for the self-programming lock control block.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/100ps
`include "spl_lock_consts.vh"
module spl_lock_control_chk #(
    parameter AW = 12
) (
    // Clock and reset
    input wire          clk_sys,
    input wire          resetn,
    // Register read channel
    input wire [3:0]    s_axi_araddr,
    input wire          s_axi_arvalid,
    input wire          s_axi_arready,
    input wire          s_axi_rvalid,
    input wire [31:0]   s_axi_rdata,
    // Core side
    input wire [AW-1:0] execAddr,
    input wire          globalIrqFlag,
    input wire          storeReq,
    input wire          loadReq,
    input wire [AW:0]   loadAddr,
    input wire          storeRefused_r,
    input wire          loadGrant_r,
    input wire          loadRefused_r,
    input wire          lockReadValid_r,
    input wire [7:0]    lockReadData_r,
    input wire          storeReadyIrq_r,
    input wire          cpuStall_r,
    input wire [AW-1:0] resetVector_r,
    // Flash and fuses
    input wire [AW-1:0] bootStart,
    input wire [AW-1:0] nrwwStart,
    input wire          flashEraseStart_r,
    input wire          flashWriteStart_r,
    input wire [AW-1:0] flashPageAddr_r,
    input wire          pageLoadWe_r,
    input wire          bootResetSelectFuse,
    input wire [7:0]    fuseLowByte
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    reg  [3:0] rdAddr_r;
    wire       opGo = flashEraseStart_r || flashWriteStart_r;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) rdAddr_r <= 4'h0;
        else if (s_axi_arvalid && s_axi_arready) rdAddr_r <= s_axi_araddr;
    end

    property p_rsv;
        s_axi_rvalid && rdAddr_r == `SPL_OFF_CSR |-> !s_axi_rdata[`SPL_CSR_RES];
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit reads one");
    property p_vec;
        $past(resetn) |->
            resetVector_r == ($past(bootResetSelectFuse) ? {AW{1'b0}} : $past(bootStart));
    endproperty
    a_vec: assert property (p_vec) else $error("reset vector wrong");
    property p_irqFlag;
        $past(resetn) && !$past(globalIrqFlag) |-> !storeReadyIrq_r;
    endproperty
    a_irqFlag: assert property (p_irqFlag) else $error("irq without flag");
    property p_irqOp;
        opGo |=> !storeReadyIrq_r [*2];
    endproperty
    a_irqOp: assert property (p_irqOp) else $error("irq while armed");
    property p_stall;
        opGo && flashPageAddr_r >= nrwwStart |-> ##[0:1] cpuStall_r;
    endproperty
    a_stall: assert property (p_stall) else $error("no stall");
    property p_peek;
        lockReadValid_r |-> $past(loadReq);
    endproperty
    a_peek: assert property (p_peek) else $error("lock read without load");
    property p_fuse;
        lockReadValid_r && $past(loadAddr[0]) |-> lockReadData_r == $past(fuseLowByte);
    endproperty
    a_fuse: assert property (p_fuse) else $error("fuse byte wrong");
    property p_one;
        loadReq |=> $onehot({lockReadValid_r, loadGrant_r, loadRefused_r});
    endproperty
    a_one: assert property (p_one) else $error("load outcome not single");
    property p_app;
        storeReq && execAddr < bootStart |=>
            storeRefused_r && !opGo && !pageLoadWe_r;
    endproperty
    a_app: assert property (p_app) else $error("store from app taken");
    property p_start;
        opGo |-> $past(storeReq);
    endproperty
    a_start: assert property (p_start) else $error("op without store");

    c_peek: cover property (lockReadValid_r);
    c_ref:  cover property (loadRefused_r);
    c_irq:  cover property (storeReadyIrq_r);
endmodule // spl_lock_control_chk

bind spl_lock_control spl_lock_control_chk #(.AW(AW)) u_chk (.*);

// ### verif/spl_lock_control_bench.sv
// Self-checking bench for the self-programming lock control block.
// Assumes the CPU/flash model and the bound port checker.
`timescale 1ns/100ps
`include "spl_lock_consts.vh"
module spl_lock_control_bench;
    localparam [11:0] EXB = 12'hc20;
    localparam [11:0] EXA = 12'h050;
    localparam [12:0] LDA = 13'h0200;
    localparam [12:0] LDB = 13'h1820;
    localparam [10:0] REF = 11'h100;
    localparam [10:0] GNT = 11'h200;
    reg         clk_sys       = 1'b0;
    reg         resetn        = 1'b0;
    reg  [3:0]  s_axi_awaddr  = 4'h0;
    reg         s_axi_awvalid = 1'b0;
    reg  [31:0] s_axi_wdata   = 32'h0;
    reg         s_axi_wvalid  = 1'b0;
    reg         s_axi_bready  = 1'b1;
    reg  [3:0]  s_axi_araddr  = 4'h0;
    reg         s_axi_arvalid = 1'b0;
    reg         s_axi_rready  = 1'b1;
    reg  [11:0] execAddr      = EXB;
    reg         irqFlag       = 1'b0;
    reg         bootFuse      = 1'b1;
    reg  [7:0]  fuseLow       = 8'h00;
    reg         chipErase     = 1'b0;
    reg         progLockWe    = 1'b0;
    reg  [7:0]  progLockData  = 8'hfe;
    reg  [31:0] rnd;
    wire        awready, wready, bvalid, arready, rvalid, ldValid, ldGrant, ldRef;
    wire        storeReq, loadReq, flashDone, eraseGo, writeGo;
    wire [1:0]  rresp;
    wire [31:0] rdata;
    wire [11:0] storeAddr;
    wire [15:0] storeWord;
    wire [12:0] loadAddr;
    wire [7:0]  ldData;
    integer     n_errors  = 0;
    integer     tests_run = 0;
    integer     i;
    reg  [33:0] rq[$];
    reg  [10:0] lq[$];

    spl_lock_control u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(wready),
        .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(s_axi_rready), .execAddr(execAddr), .globalIrqFlag(irqFlag),
        .storeReq(storeReq), .storeAddr(storeAddr), .storeWord(storeWord),
        .loadReq(loadReq), .loadAddr(loadAddr), .storeRefused_r(), .loadGrant_r(ldGrant),
        .loadRefused_r(ldRef), .lockReadValid_r(ldValid), .lockReadData_r(ldData),
        .storeReadyIrq_r(), .irqSuppress_r(), .cpuStall_r(), .resetVector_r(),
        .bootStart(12'hc00), .nrwwStart(12'hc00), .flashDone(flashDone),
        .flashEraseStart_r(eraseGo), .flashWriteStart_r(writeGo), .flashPageAddr_r(),
        .pageLoadWe_r(), .pageLoadAddr_r(), .pageLoadData_r(), .pageBufClear_r(),
        .bootResetSelectFuse(bootFuse), .fuseLowByte(fuseLow), .progLockWe(progLockWe),
        .progLockData(progLockData), .chipErase(chipErase));

    spl_cpu_model u_cpu (
        .clk_sys(clk_sys), .opStart(eraseGo || writeGo), .storeReq(storeReq),
        .storeAddr(storeAddr), .storeWord(storeWord), .loadReq(loadReq),
        .loadAddr(loadAddr), .flashDone(flashDone));

    initial forever #4 clk_sys = ~clk_sys;

    task chk_rd(input [33:0] g, input [33:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] t=%0t read got=%h exp=%h", $time, g, e);
        end
    endtask

    task chk_ld(input [10:0] g, input [10:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] t=%0t load got=%h exp=%h", $time, g, e);
        end
    endtask

    task stop_test;
        $display("errors=%0d checks=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Both run right after a rising edge; each channel drops valid when taken
    task wr(input [3:0] a, input [7:0] d);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready) s_axi_awvalid <= 1'b0;
            if (wready) s_axi_wvalid <= 1'b0;
        end while (!bvalid);
    endtask

    task rd(input [3:0] a, input [1:0] r, input [8:0] d);
        rq.push_back({r, 23'h0, d});
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arready) s_axi_arvalid <= 1'b0;
        end while (!rvalid);
    endtask

    always @(posedge clk_sys) begin
        if (rvalid && s_axi_rready) chk_rd({rresp, rdata}, rq.pop_front());
        if (ldValid || ldGrant || ldRef)
            chk_ld({ldValid, ldGrant, ldRef, ldData & {8{ldValid}}}, lq.pop_front());
    end

    // Whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        stop_test;
    end

    initial begin
        void'($urandom(86258));
        fuseLow <= $urandom;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        rd(`SPL_OFF_CSR, `SPL_RESP_OKAY, 9'h000);
        rd(4'hc, `SPL_RESP_SLVERR, 9'h000);
        wr(`SPL_OFF_LOCK, 8'h00);
        rd(`SPL_OFF_LOCK, `SPL_RESP_OKAY, 9'h1ff);
        for (i = 0; i < 2; i++) begin
            wr(`SPL_OFF_CSR, {3'h0, `SPL_CMD_LOCK});
            lq.push_back({3'b100, i ? fuseLow : 8'hff});
            u_cpu.load({LDB[12:1], i[0]});
            repeat (6) @(posedge clk_sys);
        end
        rd(`SPL_OFF_CSR, `SPL_RESP_OKAY, 9'h000);
        for (i = 0; i < 3; i++) begin
            wr(`SPL_OFF_CSR, {3'h0, `SPL_CMD_ERASE});
            u_cpu.store(i == 2 ? 12'hc80 : 12'h100, 16'h0000);
            repeat (2) @(posedge clk_sys);
            if (i < 2) lq.push_back(REF);
            if (i < 2) u_cpu.load(LDA);
            if (i == 0) wr(`SPL_OFF_CSR, {3'h0, `SPL_CMD_REEN});
            if (i == 0) u_cpu.store(12'h100, 16'h0000);
            wait (flashDone);
            @(posedge clk_sys);
            rd(`SPL_OFF_CSR, `SPL_RESP_OKAY, i < 2 ? 9'h040 : 9'h000);
            wr(`SPL_OFF_CSR, {3'h0, i == 1 ? `SPL_CMD_LOAD : `SPL_CMD_REEN});
            rnd = $urandom;
            u_cpu.store(12'h100, rnd[15:0]);
            rd(`SPL_OFF_CSR, `SPL_RESP_OKAY, 9'h000);
            lq.push_back(GNT);
            u_cpu.load(LDA);
        end
        for (i = 0; i < 2; i++) begin
            wr(`SPL_OFF_CSR, {3'h0, `SPL_CMD_LOCK});
            rnd = $urandom;
            u_cpu.store(rnd[11:0], {rnd[15:8], i ? 8'hff : 8'hf0});
            rd(`SPL_OFF_LOCK, `SPL_RESP_OKAY, 9'h1f0);
        end
        for (i = 0; i < 3; i++) begin
            execAddr <= i == 2 ? EXA : EXB;
            @(posedge clk_sys);
            lq.push_back(i == 0 ? REF : GNT);
            u_cpu.load(i == 1 ? LDB : LDA);
        end
        execAddr <= EXB;
        wr(`SPL_OFF_CSR, {3'h0, `SPL_CMD_ERASE});
        u_cpu.store(12'h100, 16'h0000);
        repeat (6) @(posedge clk_sys);
        rd(`SPL_OFF_CSR, `SPL_RESP_OKAY, 9'h000);
        execAddr <= EXA;
        wr(`SPL_OFF_CSR, {3'h0, `SPL_CMD_LOAD});
        u_cpu.store(12'h100, 16'h0000);
        chipErase <= 1'b1;
        bootFuse  <= 1'b0;
        @(posedge clk_sys);
        chipErase <= 1'b0;
        progLockWe <= 1'b1;
        @(posedge clk_sys);
        progLockWe <= 1'b0;
        rd(`SPL_OFF_LOCK, `SPL_RESP_OKAY, 9'h0fe);
        execAddr <= EXB;
        wr(`SPL_OFF_CSR, {3'h0, `SPL_CMD_LOCK});
        u_cpu.store(12'h000, 16'h00df);
        execAddr <= EXA;
        @(posedge clk_sys);
        lq.push_back(REF);
        u_cpu.load(LDB);
        irqFlag <= 1'b1;
        wr(`SPL_OFF_CSR, 8'h80);
        rd(`SPL_OFF_CSR, `SPL_RESP_OKAY, 9'h080);
        repeat (4) @(posedge clk_sys);
        stop_test;
    end
endmodule // spl_lock_control_bench
